/* File: design/tmrps_params.svh */
// constants for the timer with shared prescaler: offsets, fields, resets, counts
`ifndef TMRPS_PARAMS_SVH
`define TMRPS_PARAMS_SVH

// register offset of the timer count register on the file-register port
`define TMRPS_TMR_ADDR 8'h01

// field positions in the timer and wake configuration register
`define TMRPS_CS_BIT 5
`define TMRPS_EDGE_BIT 4
`define TMRPS_PSA_BIT 3
`define TMRPS_PS_HI 2
`define TMRPS_PS_LO 0

// reset values
`define TMRPS_OPT_RST 8'hFF
`define TMRPS_DIR_RST 6'h3F
`define TMRPS_TMR_RST 8'h00
`define TMRPS_PSC_RST 8'h00

// timing counts in instruction cycles and instruction phases (Q1 = 0 .. Q4 = 3)
`define TMRPS_INHIBIT 2'h2
`define TMRPS_Q_SAMPLE 2'h1
`define TMRPS_Q_LAST 2'h3

`endif

/* File: design/tmrps_pkg.sv */
// types shared by the timer with shared prescaler
package tmrps_pkg;

   // whole state of the timer block
   typedef struct packed {
      logic [1:0] q;
      logic [7:0] tmr;
      logic [7:0] opt;
      logic [5:0] dir_g;
      logic [5:0] dir_c;
      logic [7:0] psc;
      logic [1:0] inh;
      logic pin_d;
      logic psout_d;
      logic [7:0] rdata;
   } tmrps_state_t;

   // whole state of the phase sampler
   typedef struct packed {
      logic early;
      logic late;
      logic late_d;
   } tmrps_sync_t;

endpackage

/* File: design/tmrps_sync.sv */
// samples a level on two instruction phases and reports its rising edge
`timescale 1ns/10ps
`default_nettype none

module tmrps_sync (
   // clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // phase strobes
   input wire logic sample_early_i,
   input wire logic sample_late_i,
   // level in, edge out
   input wire logic level_i,
   output logic rise_o
);

   tmrps_pkg::tmrps_sync_t s_r;
   tmrps_pkg::tmrps_sync_t s_nxt;

   // the early sample feeds only the late one; edge detect looks at later stages
   always_comb begin
      s_nxt = s_r;
      if (sample_early_i) begin
         s_nxt.early = level_i;
      end
      if (sample_late_i) begin
         s_nxt.late = s_r.early;
         s_nxt.late_d = s_r.late;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign rise_o = sample_late_i & s_r.late & ~s_r.late_d;

endmodule

`default_nettype wire

/* File: design/tmrps_timer.sv */
// 8-bit timer/counter with prescaler shared with the watchdog
`timescale 1ns/10ps
`default_nettype none
`include "tmrps_params.svh"

// Notes on behaviour
// - count source select clear: timer mode, counting instruction cycles
// - timer mode without prescaler: count register increments once per instruction cycle
// - after a count register write, increments are held for two instruction cycles
// - count source select set: counter mode, counting external input edges
// - source edge select picks rising (0) or falling (1) external edge
// - one prescaler, given to timer when assignment is 0, watchdog when 1
// - prescaler on timer gives ratios 1:2 up to 1:256 in powers of two
// - software can neither read nor load the prescaler counter
// - without prescaler the external input passes straight to the sampler
// - prescaler output is sampled on the second and fourth phases
// - prescaled external input is divided ahead of sampling, output symmetrical
// - count register updates some phases after the qualifying external edge
// - with prescaler on timer, any count register write clears the prescaler
// - with prescaler on watchdog, watchdog clear also clears the prescaler
// - device reset leaves the prescaler counter all zeros
// - counter mode forces the external input pin's direction to input
module tmrps_timer #(
   parameter int CKI_BIT = 2,
   parameter bit CKI_ON_PORTC = 1'b0
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // file-register port
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_wdata_i,
   output logic [7:0] reg_rdata_o,
   // configuration and direction writes
   input wire logic opt_wr_i,
   input wire logic [7:0] opt_wdata_i,
   input wire logic dir_wr_i,
   input wire logic dir_sel_portc_i,
   input wire logic [5:0] dir_wdata_i,
   // watchdog side
   input wire logic watchdog_clear_command_i,
   input wire logic wdt_osc_tick_i,
   output logic wdt_tick_o,
   // external pin and state
   input wire logic external_count_input_i,
   output logic [7:0] timer_count_register_o,
   output logic [7:0] opt_o,
   output logic [5:0] dir_gpio_o,
   output logic [5:0] dir_portc_o,
   output logic [1:0] phase_o
);

   if (CKI_BIT < 0 || CKI_BIT > 5) begin : g_bad_bit
      $error("CKI_BIT must select one of the six port pins");
   end

   tmrps_pkg::tmrps_state_t s_r;
   tmrps_pkg::tmrps_state_t s_nxt;

   logic count_source_select;
   logic source_edge_select;
   logic scaler_assignment;
   logic [2:0] scale_ratio_field;
   logic cyc_end;
   logic pin_pol;
   logic pin_edge;
   logic psc_tick;
   logic psc_bit;
   logic psc_clear;
   logic sync_in;
   logic sync_rise;
   logic tmr_wr;
   logic inc_req;

   assign count_source_select = s_r.opt[`TMRPS_CS_BIT];
   assign source_edge_select = s_r.opt[`TMRPS_EDGE_BIT];
   assign scaler_assignment = s_r.opt[`TMRPS_PSA_BIT];
   assign scale_ratio_field = s_r.opt[`TMRPS_PS_HI:`TMRPS_PS_LO];
   assign cyc_end = (s_r.q == `TMRPS_Q_LAST);
   assign tmr_wr = reg_wr_i && (reg_addr_i == `TMRPS_TMR_ADDR);

   // falling-edge select just inverts the pin so one rising detector serves both
   assign pin_pol = external_count_input_i ^ source_edge_select;
   assign pin_edge = pin_pol & ~s_r.pin_d;

   // prescaler clocks from whichever party owns it
   always_comb begin
      if (scaler_assignment) begin
         psc_tick = wdt_osc_tick_i;
      end else if (count_source_select) begin
         psc_tick = pin_edge;
      end else begin
         psc_tick = cyc_end;
      end
   end

   // bit n of a binary counter rises once every 2^(n+1) ticks, square wave
   assign psc_bit = s_r.psc[scale_ratio_field];
   assign sync_in = scaler_assignment ? pin_pol : psc_bit;
   assign psc_clear = (tmr_wr && !scaler_assignment)
      || (watchdog_clear_command_i && scaler_assignment);

   tmrps_sync u_sync (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .sample_early_i(s_r.q == `TMRPS_Q_SAMPLE),
      .sample_late_i(cyc_end),
      .level_i(sync_in),
      .rise_o(sync_rise)
   );

   // plain timer mode needs no sampler; everything else waits on it
   assign inc_req = (!count_source_select && scaler_assignment) ? cyc_end
      : sync_rise;

   always_comb begin
      s_nxt = s_r;
      s_nxt.q = s_r.q + 2'h1;
      s_nxt.pin_d = pin_pol;
      s_nxt.psout_d = psc_bit;
      // a write beats a same-cycle increment and restarts the hold
      if (tmr_wr) begin
         s_nxt.tmr = reg_wdata_i;
         s_nxt.inh = `TMRPS_INHIBIT;
      end else if (cyc_end) begin
         if (s_r.inh != 2'h0) begin
            s_nxt.inh = s_r.inh - 2'h1;
         end else if (inc_req) begin
            s_nxt.tmr = s_r.tmr + 8'h01;
         end
      end
      if (psc_clear) begin
         s_nxt.psc = `TMRPS_PSC_RST;
      end else if (psc_tick) begin
         s_nxt.psc = s_r.psc + 8'h01;
      end
      if (opt_wr_i) begin
         s_nxt.opt = opt_wdata_i;
      end
      if (dir_wr_i && dir_sel_portc_i) begin
         s_nxt.dir_c = dir_wdata_i;
      end else if (dir_wr_i) begin
         s_nxt.dir_g = dir_wdata_i;
      end
      // only the count register is visible; the prescaler has no address
      if (reg_rd_i && reg_addr_i == `TMRPS_TMR_ADDR) begin
         s_nxt.rdata = s_r.tmr;
      end else if (reg_rd_i) begin
         s_nxt.rdata = 8'h00;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s_r.q <= 2'h0;
         s_r.tmr <= `TMRPS_TMR_RST;
         s_r.opt <= `TMRPS_OPT_RST;
         s_r.dir_g <= `TMRPS_DIR_RST;
         s_r.dir_c <= `TMRPS_DIR_RST;
         s_r.psc <= `TMRPS_PSC_RST;
         s_r.inh <= 2'h0;
         s_r.pin_d <= 1'b0;
         s_r.psout_d <= 1'b0;
         s_r.rdata <= 8'h00;
      end else begin
         s_r <= s_nxt;
      end
   end

   // counter mode turns the count pin into an input whatever software wrote
   always_comb begin
      dir_gpio_o = s_r.dir_g;
      dir_portc_o = s_r.dir_c;
      if (count_source_select && CKI_ON_PORTC) begin
         dir_portc_o[CKI_BIT] = 1'b1;
      end else if (count_source_select) begin
         dir_gpio_o[CKI_BIT] = 1'b1;
      end
   end

   assign wdt_tick_o = scaler_assignment & psc_bit & ~s_r.psout_d;
   assign timer_count_register_o = s_r.tmr;
   assign reg_rdata_o = s_r.rdata;
   assign opt_o = s_r.opt;
   assign phase_o = s_r.q;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   chk_write_loads: assert property (tmr_wr |=> s_r.tmr == $past(reg_wdata_i))
      else $error("count register did not take the written value");
   chk_inhibit_hold: assert property (
      (tmr_wr ##1 (!tmr_wr) [*7]) |-> s_r.tmr == $past(reg_wdata_i, 7))
      else $error("count register moved within two cycles of a write");
   chk_timer_rate: assert property (
      (cyc_end && !count_source_select && scaler_assignment && s_r.inh == 2'h0
         && !tmr_wr) |=> s_r.tmr == $past(s_r.tmr) + 8'h01)
      else $error("timer mode did not count the instruction cycle");
   chk_mid_stable: assert property (
      (!cyc_end && !tmr_wr) |=> $stable(s_r.tmr))
      else $error("count register changed away from the fourth phase");
   chk_psc_wr_clear: assert property ((tmr_wr && !scaler_assignment) |=> s_r.psc == 8'h00)
      else $error("write did not clear the timer prescaler");
   chk_psc_wdt_clear: assert property (
      (watchdog_clear_command_i && scaler_assignment) |=> s_r.psc == 8'h00)
      else $error("watchdog clear did not clear the prescaler");
   chk_psc_owner: assert property (
      (scaler_assignment && !wdt_osc_tick_i && !watchdog_clear_command_i)
         |=> $stable(s_r.psc))
      else $error("watchdog-owned prescaler moved without a watchdog tick");
   chk_dir_override: assert property (
      count_source_select |-> (CKI_ON_PORTC ? dir_portc_o[CKI_BIT] : dir_gpio_o[CKI_BIT]))
      else $error("count pin not forced to input in counter mode");
   chk_read_hides: assert property (
      (reg_rd_i && reg_addr_i != `TMRPS_TMR_ADDR) |=> reg_rdata_o == 8'h00)
      else $error("read of another address returned data");
   chk_ext_count: assert property (
      (count_source_select && !tmr_wr && s_r.inh == 2'h0 && cyc_end && !sync_rise)
         |=> $stable(s_r.tmr))
      else $error("counter mode counted without a sampled edge");

   cov_wrap: cover property (s_r.tmr == 8'hFF ##1 s_r.tmr == 8'h00);
   cov_ext_inc: cover property (count_source_select && sync_rise && s_r.inh == 2'h0);
   cov_prescaled: cover property (!scaler_assignment && scale_ratio_field == 3'h7 && sync_rise);
   cov_wdt_tick: cover property (wdt_tick_o);

endmodule

`default_nettype wire

/* File: test/tmrps_src.sv */
// square-wave source standing in for whatever drives the external count pin
`timescale 1ns/10ps
`default_nettype none
module tmrps_src #(
   parameter int HALF = 8
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // control and pin
   input wire logic run_i,
   output logic pin_o
);
   int cnt_r;
   // each level lasts HALF clocks, far above the two-phase sampling need
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cnt_r <= 0;
         pin_o <= 1'b0;
      end else if (run_i) begin
         if (cnt_r == HALF - 1) begin
            cnt_r <= 0;
            pin_o <= ~pin_o;
         end else begin
            cnt_r <= cnt_r + 1;
         end
      end
   end
endmodule
`default_nettype wire

/* File: test/tmrps_timer_tb.sv */
// self-checking bench for the timer with shared prescaler
`timescale 1ns/10ps
`default_nettype none
module tmrps_timer_tb;
   logic clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic [7:0] addr = 8'h01, wd = 8'h00, od = 8'h00, rdat, cnt, opt, t0;
   logic wr = 1'b0, rd = 1'b0, ow = 1'b0, dw = 1'b0, clr = 1'b0, wtk = 1'b0;
   logic run = 1'b0, tpin = 1'b0, spin, wto, pin;
   logic [5:0] dg, dc;
   logic [1:0] ph;
   int err_total = 0, cmp_count = 0, cyc = 0, wcnt = 0;
   always #2.5 clk_i = ~clk_i;
   // the bench takes the pin over for single edges, the source for streams
   assign pin = run ? spin : tpin;
   tmrps_timer uut (.clk_i(clk_i), .rstn_i(rstn_i), .reg_addr_i(addr),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wd), .reg_rdata_o(rdat),
      .opt_wr_i(ow), .opt_wdata_i(od), .dir_wr_i(dw), .dir_sel_portc_i(1'b0),
      .dir_wdata_i(6'h00), .watchdog_clear_command_i(clr), .wdt_osc_tick_i(wtk),
      .wdt_tick_o(wto), .external_count_input_i(pin), .timer_count_register_o(cnt),
      .opt_o(opt), .dir_gpio_o(dg), .dir_portc_o(dc), .phase_o(ph));
   tmrps_src src (.clk_i(clk_i), .rstn_i(rstn_i), .run_i(run), .pin_o(spin));
   task automatic summarize();
      if (err_total == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   always @(posedge clk_i) begin
      if (wto === 1'b1) wcnt++;
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         summarize();
      end
   end
   task automatic step(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr_tmr(input logic [7:0] d);
      wd = d;
      wr = 1'b1;
      step(1);
      wr = 1'b0;
   endtask
   task automatic wr_opt(input logic [7:0] d);
      od = d;
      ow = 1'b1;
      step(1);
      ow = 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      addr = a;
      rd = 1'b1;
      step(1);
      rd = 1'b0;
      addr = 8'h01;
      chk(rdat, e);
   endtask
   // steady counting is periodic, so a whole-period window gives an exact gain
   task automatic rate(input int win, input logic [7:0] inc);
      t0 = cnt;
      step(win);
      chk(cnt - t0, inc);
   endtask
   task automatic edge_chk(input logic lvl, input logic [7:0] inc);
      t0 = cnt;
      tpin = lvl;
      step(1);
      chk(cnt, t0);
      step(15);
      chk(cnt - t0, inc);
   endtask
   task automatic tick();
      wtk = 1'b1;
      step(1);
      wtk = 1'b0;
      step(1);
   endtask
   task automatic wclr();
      clr = 1'b1;
      step(1);
      clr = 1'b0;
   endtask
   initial begin
      step(8);
      rstn_i = 1'b1;
      chk(opt, 8'hFF);
      chk(cnt, 8'h00);
      chk({2'h0, dg}, 8'h3F);
      chk({2'h0, dc}, 8'h3F);
      chk({6'h00, ph}, 8'h00);
      wr_opt(8'h08);
      chk({6'h00, ph}, 8'h01);
      step(3);
      wr_tmr(8'hFF);
      rd_chk(8'h01, 8'hFF);
      rd_chk(8'h05, 8'h00);
      step(6);
      chk(cnt, 8'hFF);
      step(4);
      chk(cnt, 8'h00);
      step(4);
      chk(cnt, 8'h01);
      wclr();
      for (int n = 0; n < 8; n++) begin
         wr_opt({5'h00, n[2:0]});
         step(2);
         wr_tmr(8'h00);
         step((8 << n) + 16);
         rate(16 << n, 8'h02);
      end
      wr_tmr(8'h40);
      step(400);
      wr_tmr(8'h40);
      step(400);
      chk(cnt, 8'h40);
      wclr();
      wr_tmr(8'h00);
      wr_opt(8'h28);
      dw = 1'b1;
      step(1);
      dw = 1'b0;
      chk({2'h0, dg}, 8'h04);
      step(16);
      edge_chk(1'b1, 8'h01);
      wr_opt(8'h38);
      step(16);
      edge_chk(1'b0, 8'h01);
      edge_chk(1'b1, 8'h00);
      wclr();
      wr_opt(8'h20);
      run = 1'b1;
      step(64);
      rate(320, 8'h0A);
      wr_opt(8'h28);
      step(64);
      rate(320, 8'h14);
      run = 1'b0;
      wr_opt(8'h09);
      wclr();
      wcnt = 0;
      tick();
      wclr();
      tick();
      chk(wcnt[7:0], 8'h00);
      tick();
      step(2);
      chk(wcnt[7:0], 8'h01);
      repeat (8) tick();
      step(2);
      chk(wcnt[7:0], 8'h03);
      summarize();
   end
endmodule
`default_nettype wire
